// ### test/tb_top.sv
/*
  Self-checking bench for pfu_core: random instruction stream against a
  behavioural model, with APB setup and readback of PC and STATUS.
  Assumes the pfu_pkg package and the hand-over timing of the core.
*/
module tb_top import pfu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic              pclk = 1'b0;
  logic              presetn = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [7:0]        paddr = 8'h00;
  logic [31:0]       pwdata = 32'h0;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              ins_valid = 1'b0;
  pfu_instr_t        ins = '0;
  logic              ins_ready;
  logic              retire;
  logic [15:0]       pc;
  logic [7:0]        status_register;
  pfu_io_wr_t        io_wr;
  pfu_stack_t        stk;
  logic [15:0]       stk_rdata = 16'h0;
  int                err_total = 0;
  int                total_checks = 0;
  logic [15:0]       m_pc;
  logic [7:0]        m_status_register;
  logic              m_err;
  logic [15:0]       m_pop;

  pfu_core i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .ins_valid, .ins, .ins_ready,
    .retire, .pc, .status_register, .io_wr, .stk, .stk_rdata);

  // 100 MHz core clock
  always #5 pclk = ~pclk;

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic conclude;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // APB master; waits for pready instead of assuming zero wait
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    if (pready !== 1'b1) chk("apb ready", 32'h1, 32'h0);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Branch conditions; clear-type variants are the inverse of their pair
  function automatic logic brc(input pfu_op_t o, input logic [7:0] s,
                               input logic [2:0] k);
    logic f;
    case (o)
      OP_BR_FLAG_SET, OP_BR_FLAG_CLR: f = s[k];
      OP_BR_EQUAL, OP_BR_NOT_EQUAL: f = s[FL_Z];
      OP_BR_MINUS, OP_BR_PLUS: f = s[FL_N];
      OP_BR_CARRY_SET, OP_BR_CARRY_CLR, OP_BR_LOWER,
      OP_BR_SAME_HIGHER: f = s[FL_C];
      OP_BR_SIGNED_LESS, OP_BR_SIGNED_GE: f = s[FL_N] ^ s[FL_V];
      OP_BR_HALF_SET, OP_BR_HALF_CLR: f = s[FL_H];
      OP_BR_XFER_SET, OP_BR_XFER_CLR: f = s[FL_T];
      OP_BR_OVF_SET, OP_BR_OVF_CLR: f = s[FL_V];
      OP_BR_IRQ_EN, OP_BR_IRQ_DIS: f = s[FL_I];
      default: return 1'b0;
    endcase
    return f ^ (o inside {OP_BR_FLAG_CLR, OP_BR_NOT_EQUAL, OP_BR_PLUS,
      OP_BR_CARRY_CLR, OP_BR_SAME_HIGHER, OP_BR_SIGNED_GE, OP_BR_HALF_CLR,
      OP_BR_XFER_CLR, OP_BR_OVF_CLR, OP_BR_IRQ_DIS});
  endfunction

  // Reference model: length, next pc, stack and I/O traffic, flags
  task automatic model(input pfu_instr_t x, output int n,
                       output logic [15:0] np, output logic [16:0] ps,
                       output logic pp, output logic [14:0] iw);
    logic [15:0] rel;
    logic [8:0]  r;
    logic [7:0]  a;
    logic [7:0]  b;
    logic [7:0]  s;
    logic [7:0]  m;
    logic        t;
    logic        ok;
    logic        ci;
    logic [4:0]  hc;
    a = x.opnd_a;
    b = x.opnd_b;
    s = m_status_register;
    m = 8'h01 << x.bit_sel;
    rel = m_pc + {{4{x.offset[11]}}, x.offset} + 16'h0001;
    ok = x.io_addr <= IO_BIT_LIMIT;
    n = 1;
    np = m_pc + 16'h0001;
    ps = '0;
    pp = 1'b0;
    iw = '0;
    t = 1'b0;
    case (x.op)
      OP_RELATIVE_JUMP: begin n = 2; np = rel; end
      OP_POINTER_JUMP: begin n = 2; np = x.target; end
      OP_ABSOLUTE_JUMP: begin n = 3; np = x.target; end
      OP_REL_CALL: begin n = 4; np = rel; ps = {1'b1, np - rel + m_pc + 16'h1}; end
      OP_PTR_CALL: begin n = 4; np = x.target; ps = {1'b1, m_pc + 16'h1}; end
      OP_ABS_CALL: begin n = 5; np = x.target; ps = {1'b1, m_pc + 16'h2}; end
      OP_SUB_EXIT: begin n = 5; np = m_pop; pp = 1'b1; end
      OP_IRQ_EXIT: begin n = 5; np = m_pop; pp = 1'b1; m_status_register[FL_I] = 1'b1; end
      OP_REG_CMP, OP_CMP_CARRY, OP_CMP_IMM: begin
        r = {1'b0, a} - {1'b0, b} - {8'h0, x.op == OP_CMP_CARRY && s[FL_C]};
        m_status_register[FL_C] = r[8];
        m_status_register[FL_Z] = r[7:0] == 8'h0 && (x.op != OP_CMP_CARRY || s[FL_Z]);
        m_status_register[FL_N] = r[7];
        m_status_register[FL_V] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
        ci = x.op == OP_CMP_CARRY && s[FL_C];
        hc = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ci};
        m_status_register[FL_H] = hc[4];
        m_status_register[FL_S] = m_status_register[FL_N] ^ m_status_register[FL_V];
      end
      OP_CMP_SKIP: t = a == b;
      OP_SKIP_REG_CLR: t = (a & m) == 8'h0;
      OP_SKIP_REG_SET: t = (a & m) != 8'h0;
      OP_SKIP_IO_CLR, OP_SKIP_IO_SET: begin
        t = ok && (((a & m) != 8'h0) == (x.op == OP_SKIP_IO_SET));
        m_err = m_err | !ok;
      end
      OP_IO_BIT_SET, OP_IO_BIT_CLR: begin
        n = 2;
        m_err = m_err | !ok;
        if (ok) iw = {1'b1, x.io_addr, x.op == OP_IO_BIT_SET ? a | m : a & ~m};
      end
      default: t = brc(x.op, s, x.bit_sel);
    endcase
    if (t && x.op inside {[OP_BR_FLAG_SET:OP_BR_IRQ_DIS]}) begin
      n = 2;
      np = rel;
    end else if (t) begin
      n = x.next_long ? 3 : 2;
      np = m_pc + (x.next_long ? PC_SKIP_TWO : PC_SKIP_ONE);
    end
  endtask

  // One instruction: preset pc and flags over APB, issue, watch, compare
  task automatic run_one(input pfu_instr_t x);
    int          n;
    int          k;
    logic [15:0] np;
    logic [16:0] ps;
    logic [16:0] gps;
    logic        pp;
    logic        gpp;
    logic        bad;
    logic [14:0] iw;
    logic [14:0] giw;
    logic [31:0] q;
    logic        e;
    apb(1'b1, ADDR_PC, {16'h0, m_pc}, q, e);
    apb(1'b1, ADDR_STAT, {23'h0, 1'b1, m_status_register}, q, e);
    m_err = 1'b0;
    model(x, n, np, ps, pp, iw);
    @(posedge pclk);
    ins <= x;
    ins_valid <= 1'b1;
    stk_rdata <= m_pop;
    @(posedge pclk);
    ins_valid <= 1'b0;
    k = 0;
    gps = '0;
    gpp = 1'b0;
    giw = '0;
    bad = 1'b0;
    do begin
      #1;
      k++;
      if (stk.push === 1'b1) gps = {1'b1, stk.data};
      if (stk.pop === 1'b1) gpp = 1'b1;
      if (io_wr.we === 1'b1) giw = {1'b1, io_wr.addr, io_wr.data};
      if (ins_ready !== retire) bad = 1'b1;
      if (retire !== 1'b1) @(posedge pclk);
    end while (retire !== 1'b1 && k < 8);
    m_pc = np;
    chk("cycles", 32'(n), 32'(k));
    chk("pc", 32'(m_pc), 32'(pc));
    chk("status_register", 32'(m_status_register), 32'(status_register));
    chk("push", 32'(ps), 32'(gps));
    chk("pop", 32'(pp), 32'(gpp));
    chk("io write", 32'(iw), 32'(giw));
    chk("ready", 32'h0, 32'(bad));
    apb(1'b0, ADDR_STAT, 32'h0, q, e);
    chk("status", {23'h0, m_err, m_status_register}, q);
    apb(1'b0, ADDR_PC, 32'h0, q, e);
    chk("pc read", {16'h0, m_pc}, q);
  endtask

  // Hang guard, well beyond the few thousand cycles the run needs
  initial begin
    #300000;
    err_total++;
    conclude;
  end

  // Main sequence
  initial begin
    pfu_instr_t  x;
    logic [63:0] rr;
    logic [31:0] r3;
    logic [31:0] q;
    logic        e;
    void'($urandom(32'h597c1295));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    chk("reset pc", 32'h0, 32'(pc));
    chk("reset ready", 32'h1, 32'(ins_ready));
    apb(1'b0, ADDR_CTRL, 32'h0, q, e);
    chk("ctrl", 32'h1, q);
    apb(1'b0, 8'h0c, 32'h0, q, e);
    chk("unmapped err", 32'h1, 32'(e));
    chk("unmapped data", 32'h0, q);
    // Every operation except OP_NOP several times with random operands and flags
    for (int p = 0; p < 4; p++) begin
      for (int i = 1; i <= OP_IO_BIT_CLR; i++) begin
        rr = {$urandom, $urandom};
        r3 = $urandom;
        x = rr[59:0];
        x.op = pfu_op_t'(i);
        if (rr[63]) x.opnd_b = x.opnd_a;
        m_pc = r3[15:0];
        m_status_register = r3[23:16];
        m_pop = rr[15:0] ^ r3[31:16];
        run_one(x);
      end
    end
    // Disabled unit must refuse an offered jump
    apb(1'b1, ADDR_CTRL, 32'h0, q, e);
    @(posedge pclk);
    ins.op <= OP_RELATIVE_JUMP;
    ins_valid <= 1'b1;
    repeat (3) @(posedge pclk);
    #1;
    chk("ready off", 32'h0, 32'(ins_ready));
    chk("pc held", 32'(m_pc), 32'(pc));
    @(posedge pclk);
    ins_valid <= 1'b0;
    apb(1'b1, ADDR_CTRL, 32'h1, q, e);
    conclude;
  end
endmodule

// ### verilog/pfu_cmp.sv
/*
  Compare flag calculator: forms a minus b minus carry and derives the
  status flags without producing a result for any register.
  Purely combinational; the caller registers the flags.
*/
module pfu_cmp
  import pfu_pkg::*;
(
  input  wire logic [7:0] a,     // Minuend
  input  wire logic [7:0] b,     // Subtrahend
  input  wire logic       cin,   // Borrow in
  input  wire logic       chain, // Keep zero only if it was set
  input  wire logic       zin,   // Previous zero flag
  output pfu_flags_t      flags  // Resulting flags
);
  logic [7:0] r;

  // Borrow terms per the two's complement subtract
  always_comb begin
    r       = a - b - {7'h00, cin};
    flags.c = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
    flags.h = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
    flags.v = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
    flags.n = r[7];
    flags.z = (r == 8'h00) & (chain ? zin : 1'b1);
    flags.s = flags.n ^ flags.v;
  end
endmodule

// ### verilog/pfu_cond.sv
/*
  Condition evaluator: decides whether a skip or branch is taken from
  the status register and the operand values. Combinational only.
*/
module pfu_cond
  import pfu_pkg::*;
(
  input  wire pfu_op_t    op,    // Operation
  input  wire logic [7:0] status_register,  // Current status flags
  input  wire logic [7:0] a,     // First operand
  input  wire logic [7:0] b,     // Second operand
  input  wire logic [2:0] sel,   // Bit or flag index
  output logic            take   // Condition holds
);
  logic abit;

  always_comb begin
    abit = a[sel];
    unique case (op)
      OP_CMP_SKIP:       take = (a == b);
      OP_SKIP_REG_CLR,
      OP_SKIP_IO_CLR:    take = ~abit;
      OP_SKIP_REG_SET,
      OP_SKIP_IO_SET:    take = abit;
      OP_BR_FLAG_SET:    take = status_register[sel];
      OP_BR_FLAG_CLR:    take = ~status_register[sel];
      OP_BR_EQUAL:       take = status_register[FL_Z];
      OP_BR_NOT_EQUAL:   take = ~status_register[FL_Z];
      OP_BR_MINUS:       take = status_register[FL_N];
      OP_BR_PLUS:        take = ~status_register[FL_N];
      OP_BR_CARRY_SET,
      OP_BR_LOWER:       take = status_register[FL_C];
      OP_BR_CARRY_CLR,
      OP_BR_SAME_HIGHER: take = ~status_register[FL_C];
      OP_BR_SIGNED_GE:   take = ~(status_register[FL_N] ^ status_register[FL_V]);
      OP_BR_SIGNED_LESS: take = status_register[FL_N] ^ status_register[FL_V];
      OP_BR_HALF_SET:    take = status_register[FL_H];
      OP_BR_HALF_CLR:    take = ~status_register[FL_H];
      OP_BR_XFER_SET:    take = status_register[FL_T];
      OP_BR_XFER_CLR:    take = ~status_register[FL_T];
      OP_BR_OVF_SET:     take = status_register[FL_V];
      OP_BR_OVF_CLR:     take = ~status_register[FL_V];
      OP_BR_IRQ_EN:      take = status_register[FL_I];
      OP_BR_IRQ_DIS:     take = ~status_register[FL_I];
      default:           take = 1'b0;
    endcase
  end
endmodule

// ### verilog/pfu_core.sv
/*
  Program flow unit: executes jumps, calls, returns, compares, skips,
  flag branches and single-bit I/O writes from a pre-decoded stream,
  owns the program counter and status register, and exposes them over
  APB. Assumes operands, the stack and the I/O space answer on pclk.
*/
// Notes on behaviour
// - Relative jump goes to pc+offset+1, pointer jump to Z, both in 2 cycles, absolute jump in 3.
// - Relative and pointer calls save the return address and reach their target in 4 cycles.
// - Absolute call takes 5 cycles and both returns reload pc from the stack in 5 cycles.
// - Compare-skip skips the next instruction when both registers are equal.
// - The three compares only update Z, N, V, C, H and S, in one cycle.
// - Register bit skips test one register bit for clear or set.
// - I/O bit skips test one I/O register bit for clear or set.
// - Generic flag branches test the selected status bit and add offset+1 when taken.
// - Equal and not-equal follow Z, minus and plus follow N.
// - Carry-set and lower branch on C set, carry-clear and same-or-higher on C clear.
// - Signed greater-or-equal branches on N xor V clear, signed less on it set.
// - Half-carry, transfer and overflow flags each have a set and a clear branch.
// - Interrupt enabled and disabled branches follow the global I flag.
// - I/O bit set and clear force one bit of an I/O register in 2 cycles.
// - Single-bit I/O work is allowed only at I/O addresses 0x00 to 0x1F.
// - A single-bit I/O write rewrites the whole register from its read value.
module pfu_core
  import pfu_pkg::*;
(
  input  wire logic              pclk,      // Core clock
  input  wire logic              presetn,   // Async reset, active low
  input  wire logic              psel,      // APB select
  input  wire logic              penable,   // APB access phase
  input  wire logic              pwrite,    // APB write
  input  wire logic [APB_AW-1:0] paddr,     // APB byte address
  input  wire logic [31:0]       pwdata,    // APB write data
  output logic [31:0]            prdata,    // APB read data
  output logic                   pready,    // APB ready
  output logic                   pslverr,   // APB error
  input  wire logic              ins_valid, // Instruction offered
  input  wire pfu_instr_t        ins,       // Instruction and operands
  output logic                   ins_ready, // Unit can take one
  output logic                   retire,    // Instruction finished
  output logic [15:0]            pc,        // Program counter
  output logic [7:0]             status_register,      // Status register
  output pfu_io_wr_t             io_wr,     // I/O register write
  output pfu_stack_t             stk,       // Stack push or pop
  input  wire logic [15:0]       stk_rdata  // Popped word, with pop
);
  pfu_state_t st;
  pfu_state_t next_st;
  pfu_flags_t flags;
  logic       take;
  logic       issue;
  logic       in_range;
  logic       chain;
  logic [15:0] pc_inc;
  logic [15:0] rel_dest;
  logic [15:0] skip_dest;

  // Only the compare-with-carry chains borrow and zero
  assign chain = (ins.op == OP_CMP_CARRY);

  pfu_cmp u_cmp (
    .a     (ins.opnd_a),
    .b     (ins.opnd_b),
    .cin   (chain & st.status_register[FL_C]),
    .chain (chain),
    .zin   (st.status_register[FL_Z]),
    .flags (flags)
  );

  pfu_cond u_cond (
    .op   (ins.op),
    .status_register (st.status_register),
    .a    (ins.opnd_a),
    .b    (ins.opnd_b),
    .sel  (ins.bit_sel),
    .take (take)
  );

  // Address arithmetic shared by every flow change
  always_comb begin
    issue     = ins_valid & st.ready;
    in_range  = (ins.io_addr <= IO_BIT_LIMIT);
    pc_inc    = st.pc + PC_STEP;
    rel_dest  = pc_inc + {{4{ins.offset[11]}}, ins.offset};
    skip_dest = st.pc + (ins.next_long ? PC_SKIP_TWO
                                       : PC_SKIP_ONE);
  end

  // Sequencer, status flags and APB slave in one state update
  always_comb begin
    logic [2:0]  cyc;
    logic [15:0] dst;
    cyc = CYC_ONE;
    dst = pc_inc;
    next_st          = st;
    next_st.io.we    = 1'b0;
    next_st.stk.push = 1'b0;
    next_st.stk.pop  = 1'b0;
    next_st.done     = 1'b0;
    next_st.pready   = 1'b0;
    next_st.pslverr  = 1'b0;

    // APB: answer decoded in setup, zero wait states
    if (psel && !penable) begin
      next_st.pready = 1'b1;
      unique case (paddr)
        ADDR_CTRL: next_st.prdata = {31'h0, st.enable};
        ADDR_PC:   next_st.prdata = {16'h0, st.pc};
        ADDR_STAT: next_st.prdata = {23'h0, st.range_err, st.status_register};
        default: begin
          next_st.prdata  = 32'h0;
          next_st.pslverr = 1'b1;
        end
      endcase
    end
    if (psel && penable && st.pready && pwrite && !st.pslverr) begin
      unique case (paddr)
        ADDR_CTRL: next_st.enable = pwdata[0];
        ADDR_PC:   next_st.pc = pwdata[15:0];
        ADDR_STAT: begin
          next_st.status_register = pwdata[7:0];
          if (pwdata[STAT_ERR]) next_st.range_err = 1'b0;
        end
        default: next_st.prdata = st.prdata;
      endcase
    end

    // Return address arrives while pop is shown
    if (st.stk.pop) next_st.dest = stk_rdata;

    // Multi-cycle countdown; pc changes only at completion
    if (st.busy) begin
      next_st.cnt = st.cnt - 3'h1;
      if (st.cnt == 3'h1) begin
        next_st.busy = 1'b0;
        next_st.done = 1'b1;
        next_st.pc   = st.dest;
        if (st.set_irq) next_st.status_register[FL_I] = 1'b1;
        next_st.set_irq = 1'b0;
      end
    end

    if (issue) begin
      unique case (ins.op)
        OP_RELATIVE_JUMP: begin
          cyc = CYC_SHORT_JMP;
          dst = rel_dest;
        end
        OP_POINTER_JUMP: begin
          cyc = CYC_SHORT_JMP;
          dst = ins.target;
        end
        OP_ABSOLUTE_JUMP: begin
          cyc = CYC_ABS_JMP;
          dst = ins.target;
        end
        OP_REL_CALL, OP_PTR_CALL: begin
          cyc = CYC_SHORT_CALL;
          dst = (ins.op == OP_REL_CALL) ? rel_dest : ins.target;
          next_st.stk.push = 1'b1;
          next_st.stk.data = pc_inc;
        end
        OP_ABS_CALL: begin
          cyc = CYC_LONG;
          dst = ins.target;
          next_st.stk.push = 1'b1;
          next_st.stk.data = st.pc + PC_SKIP_ONE;
        end
        OP_SUB_EXIT, OP_IRQ_EXIT: begin
          cyc = CYC_LONG;
          next_st.stk.pop = 1'b1;
          next_st.set_irq = (ins.op == OP_IRQ_EXIT);
        end
        OP_REG_CMP, OP_CMP_CARRY, OP_CMP_IMM: begin
          next_st.status_register[FL_Z] = flags.z;
          next_st.status_register[FL_N] = flags.n;
          next_st.status_register[FL_V] = flags.v;
          next_st.status_register[FL_C] = flags.c;
          next_st.status_register[FL_H] = flags.h;
          next_st.status_register[FL_S] = flags.s;
        end
        OP_CMP_SKIP, OP_SKIP_REG_CLR, OP_SKIP_REG_SET: begin
          if (take) begin
            cyc = ins.next_long ? CYC_ABS_JMP : CYC_SHORT_JMP;
            dst = skip_dest;
          end
        end
        OP_SKIP_IO_CLR, OP_SKIP_IO_SET: begin
          if (!in_range) begin
            next_st.range_err = 1'b1;
          end else if (take) begin
            cyc = ins.next_long ? CYC_ABS_JMP : CYC_SHORT_JMP;
            dst = skip_dest;
          end
        end
        OP_IO_BIT_SET, OP_IO_BIT_CLR: begin
          cyc = CYC_IO_BIT;
          if (!in_range) begin
            next_st.range_err = 1'b1;
          end else begin
            // Whole byte goes back, so set W1C flags clear too
            next_st.io.we   = 1'b1;
            next_st.io.addr = ins.io_addr;
            next_st.io.data = ins.opnd_a;
            next_st.io.data[ins.bit_sel] =
              (ins.op == OP_IO_BIT_SET);
          end
        end
        default: begin
          if (take) begin
            cyc = CYC_SHORT_JMP;
            dst = rel_dest;
          end
        end
      endcase
      if (cyc == CYC_ONE) begin
        next_st.pc   = dst;
        next_st.done = 1'b1;
      end else begin
        next_st.busy = 1'b1;
        next_st.cnt  = cyc - 3'h1;
        if (ins.op != OP_SUB_EXIT && ins.op != OP_IRQ_EXIT)
          next_st.dest = dst;
      end
    end
    next_st.ready = ~next_st.busy & next_st.enable;
  end

  // Single state register, constants only under reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st        <= '0;
      st.pc     <= PC_RST;
      st.status_register   <= STATUS_REGISTER_RST;
      st.enable <= ENABLE_RST;
      st.ready  <= ENABLE_RST;
    end else begin
      st <= next_st;
    end
  end

  assign prdata    = st.prdata;
  assign pready    = st.pready;
  assign pslverr   = st.pslverr;
  assign ins_ready = st.ready;
  assign retire    = st.done;
  assign pc        = st.pc;
  assign status_register      = st.status_register;
  assign io_wr     = st.io;
  assign stk       = st.stk;

  // Checks on timing and effects of each instruction class
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_rel_jump_dest: assert property (
    issue && ins.op == OP_RELATIVE_JUMP |=> st.busy ##1
      (!st.busy && st.pc == $past(rel_dest, 2)))
    else $error("relative jump target or length wrong");

  a_abs_jump_len: assert property (
    issue && ins.op == OP_ABSOLUTE_JUMP |=> st.busy [*2] ##1
      (st.done && st.pc == $past(ins.target, 3)))
    else $error("absolute jump not done in three cycles");

  a_call_push_ret: assert property (
    issue && ins.op == OP_REL_CALL |=> (stk.push &&
      stk.data == $past(st.pc) + PC_STEP) ##3
      (st.done && st.pc == $past(rel_dest, 4)))
    else $error("relative call push or target wrong");

  a_exit_restore: assert property (
    issue && (ins.op == OP_SUB_EXIT || ins.op == OP_IRQ_EXIT) |=>
      stk.pop ##4 (st.done && st.pc == $past(stk_rdata, 4)))
    else $error("return did not restore pc in five cycles");

  a_cmp_flags: assert property (
    issue && ins.op == OP_REG_CMP |=> !st.busy && st.done &&
      st.status_register[FL_Z] == ($past(ins.opnd_a) == $past(ins.opnd_b)))
    else $error("compare zero flag or length wrong");

  a_skip_two_word: assert property (
    issue && take && ins.next_long && ins.op == OP_SKIP_REG_SET |->
      ##3 (st.pc == $past(st.pc, 3) + PC_SKIP_TWO))
    else $error("skip over long instruction wrong");

  a_branch_not_taken: assert property (
    issue && ins.op >= OP_BR_FLAG_SET && ins.op <= OP_BR_IRQ_DIS &&
      !take |=> !st.busy && st.pc == $past(st.pc) + PC_STEP)
    else $error("untaken branch not one cycle");

  a_io_bit_write: assert property (
    issue && ins.op == OP_IO_BIT_SET && in_range |=> io_wr.we &&
      io_wr.data == ($past(ins.opnd_a) | (8'h01 << $past(ins.bit_sel)))
      ##1 st.done)
    else $error("io bit set wrong data or length");

  a_io_range: assert property (
    issue && !in_range && (ins.op == OP_IO_BIT_SET ||
      ins.op == OP_IO_BIT_CLR) |=> !io_wr.we && st.range_err)
    else $error("out of range io bit write done");

  // Pointer call pushes the next word and lands on Z after four cycles
  a_ptr_call_len: assert property (
    issue && ins.op == OP_PTR_CALL |=> (stk.push &&
      stk.data == $past(pc_inc)) ##3
      (st.done && st.pc == $past(ins.target, 4)))
    else $error("pointer call push or target wrong");

  a_abs_call_len: assert property (
    issue && ins.op == OP_ABS_CALL |=> stk.push ##4
      (st.done && st.pc == $past(ins.target, 5)))
    else $error("absolute call not done in five cycles");

  // I only comes back with the final pc, never earlier
  a_irq_exit_flag: assert property (
    issue && ins.op == OP_IRQ_EXIT |-> ##5 (st.done && st.status_register[FL_I]))
    else $error("interrupt exit left I flag clear");

  a_io_skip_miss: assert property (
    issue && ins.op == OP_SKIP_IO_CLR && in_range && !take |=>
      st.done && st.pc == $past(pc_inc))
    else $error("untaken io skip not one cycle");

  a_branch_taken: assert property (
    issue && take && ins.op == OP_BR_EQUAL |=> st.busy ##1
      (st.done && st.pc == $past(rel_dest, 2)))
    else $error("taken branch target or length wrong");

  a_io_bit_clear: assert property (
    issue && ins.op == OP_IO_BIT_CLR && in_range |=> io_wr.we &&
      io_wr.data == ($past(ins.opnd_a) & ~(8'h01 << $past(ins.bit_sel))))
    else $error("io bit clear wrong data");

  // Sticky error only drops on an explicit write-one clear
  a_range_sticky: assert property (
    st.range_err && !(psel && penable && st.pready && pwrite &&
      paddr == ADDR_STAT && pwdata[STAT_ERR]) |=> st.range_err)
    else $error("range error flag lost");

  c_call_return: cover property (
    issue && ins.op == OP_ABS_CALL ##[5:20]
      issue && ins.op == OP_SUB_EXIT);
  c_skip_taken: cover property (issue && take &&
    ins.op == OP_CMP_SKIP);
  c_branch_taken: cover property (issue && take &&
    ins.op == OP_BR_SIGNED_LESS);
  c_apb_write: cover property (psel && penable && pready && pwrite);
endmodule

// ### verilog/pfu_pkg.sv
/*
  Shared types and constants of the program flow unit: operation codes,
  the pre-decoded instruction carrier, port groups, state, timing and
  register map. Assumes a single 100 MHz core clock.
*/
package pfu_pkg;
  localparam int unsigned CLK_MHZ = 100;

  // Execution lengths in core cycles
  localparam logic [2:0] CYC_ONE       = 3'h1;
  localparam logic [2:0] CYC_SHORT_JMP = 3'h2;
  localparam logic [2:0] CYC_ABS_JMP   = 3'h3;
  localparam logic [2:0] CYC_SHORT_CALL = 3'h4;
  localparam logic [2:0] CYC_LONG      = 3'h5;
  localparam logic [2:0] CYC_IO_BIT    = 3'h2;

  // Program counter steps
  localparam logic [15:0] PC_STEP      = 16'h0001;
  localparam logic [15:0] PC_SKIP_ONE  = 16'h0002;
  localparam logic [15:0] PC_SKIP_TWO  = 16'h0003;
  localparam logic [15:0] PC_RST       = 16'h0000;

  // Highest bit-addressable I/O register
  localparam logic [5:0] IO_BIT_LIMIT = 6'h1f;

  // Status register bit positions
  localparam int unsigned FL_C = 0;
  localparam int unsigned FL_Z = 1;
  localparam int unsigned FL_N = 2;
  localparam int unsigned FL_V = 3;
  localparam int unsigned FL_S = 4;
  localparam int unsigned FL_H = 5;
  localparam int unsigned FL_T = 6;
  localparam int unsigned FL_I = 7;
  localparam logic [7:0] STATUS_REGISTER_RST = 8'h00;

  // APB register map (byte addresses)
  localparam int unsigned APB_AW    = 8;
  localparam logic [7:0] ADDR_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_PC    = 8'h04;
  localparam logic [7:0] ADDR_STAT  = 8'h08;
  localparam int unsigned STAT_ERR  = 8;
  localparam logic ENABLE_RST       = 1'b1;

  typedef enum logic [5:0] {
    OP_NOP, OP_RELATIVE_JUMP, OP_POINTER_JUMP, OP_ABSOLUTE_JUMP,
    OP_REL_CALL, OP_PTR_CALL, OP_ABS_CALL, OP_SUB_EXIT, OP_IRQ_EXIT,
    OP_CMP_SKIP, OP_REG_CMP, OP_CMP_CARRY, OP_CMP_IMM,
    OP_SKIP_REG_CLR, OP_SKIP_REG_SET, OP_SKIP_IO_CLR, OP_SKIP_IO_SET,
    OP_BR_FLAG_SET, OP_BR_FLAG_CLR, OP_BR_EQUAL, OP_BR_NOT_EQUAL,
    OP_BR_CARRY_SET, OP_BR_CARRY_CLR, OP_BR_SAME_HIGHER, OP_BR_LOWER,
    OP_BR_MINUS, OP_BR_PLUS, OP_BR_SIGNED_GE, OP_BR_SIGNED_LESS,
    OP_BR_HALF_SET, OP_BR_HALF_CLR, OP_BR_XFER_SET, OP_BR_XFER_CLR,
    OP_BR_OVF_SET, OP_BR_OVF_CLR, OP_BR_IRQ_EN, OP_BR_IRQ_DIS,
    OP_IO_BIT_SET, OP_IO_BIT_CLR
  } pfu_op_t;

  // Pre-decoded instruction with its operand values already fetched
  typedef struct packed {
    pfu_op_t     op;
    logic [7:0]  opnd_a;    // Rd, Rr or I/O register value
    logic [7:0]  opnd_b;    // Rr or immediate
    logic [2:0]  bit_sel;   // Bit or status flag index
    logic [11:0] offset;    // Signed relative offset
    logic [15:0] target;    // Z pointer or absolute address
    logic [5:0]  io_addr;   // I/O register address
    logic        next_long; // Following instruction is two words
  } pfu_instr_t;

  typedef struct packed {
    logic       we;
    logic [5:0] addr;
    logic [7:0] data;
  } pfu_io_wr_t;

  typedef struct packed {
    logic        push;
    logic        pop;
    logic [15:0] data;
  } pfu_stack_t;

  typedef struct packed {
    logic        z;
    logic        n;
    logic        v;
    logic        c;
    logic        h;
    logic        s;
  } pfu_flags_t;

  typedef struct packed {
    logic [15:0] pc;
    logic [7:0]  status_register;
    logic        enable;
    logic        range_err;
    logic        ready;
    logic        busy;
    logic [2:0]  cnt;
    logic [15:0] dest;
    logic        set_irq;
    logic        done;
    pfu_io_wr_t  io;
    pfu_stack_t  stk;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } pfu_state_t;
endpackage
